// ### design/dls_pkg.sv
// Purpose: Shared constants and types of the link test supervisor
// Assumes: 250 MHz system clock, millisecond tick for all timeouts
// Notes: Times stand in their own unit; counts derive from them
package dls_pkg;

  // ----------------------------------------------------------------
  // Clock and tick
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 250000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_KHZ * TICK_MS;
  localparam int MS_PER_S = 1000;
  localparam int MSW = 16;

  // ----------------------------------------------------------------
  // Timeouts
  // ----------------------------------------------------------------
  localparam int START_TO_S = 50;
  localparam int DATA_TO_S = 4;
  localparam int PAT_RST_TO_S = 60;
  localparam int RDL_TO_S = 60;
  localparam int PAT_RUN_S = 45;
  localparam int BRK_NS_S = 10;
  localparam int RATE_BLINK_MS = 200;
  localparam int FLASH_MS = 400;
  localparam int ER_PULSE_MS = 50;

  localparam logic [MSW-1:0] START_TO = MSW'(START_TO_S * MS_PER_S / TICK_MS);
  localparam logic [MSW-1:0] DATA_TO = MSW'(DATA_TO_S * MS_PER_S / TICK_MS);
  localparam logic [MSW-1:0] PAT_RST_TO = MSW'(PAT_RST_TO_S * MS_PER_S / TICK_MS);
  localparam logic [MSW-1:0] RDL_TO = MSW'(RDL_TO_S * MS_PER_S / TICK_MS);
  localparam logic [MSW-1:0] PAT_RUN = MSW'(PAT_RUN_S * MS_PER_S / TICK_MS);
  localparam logic [MSW-1:0] BRK_NS = MSW'(BRK_NS_S * MS_PER_S / TICK_MS);
  localparam logic [MSW-1:0] BLINK_HALF = MSW'(RATE_BLINK_MS / 2 / TICK_MS);
  localparam logic [MSW-1:0] FLASH_LEN = MSW'(FLASH_MS / TICK_MS);
  localparam logic [MSW-1:0] ER_PULSE = MSW'(ER_PULSE_MS / TICK_MS);
  localparam logic [MSW-1:0] MS_ZERO = 16'h0000;
  localparam logic [MSW-1:0] MS_ONE = 16'h0001;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int AW = 8;
  localparam logic [AW-1:0] CTRL_OFF = 8'h00;
  localparam logic [AW-1:0] STAT_OFF = 8'h04;
  localparam int CTRL_LOOP_BIT = 0;
  localparam int CTRL_PAT_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Synchronised pins
  // ----------------------------------------------------------------
  localparam int PIN_N = 6;
  localparam int PIN_LOOP_SW = 0;
  localparam int PIN_PAT_SW = 1;
  localparam int PIN_DTE_LOOP = 2;
  localparam int PIN_DTE_PAT = 3;
  localparam int PIN_TXD = 4;
  localparam int PIN_RXD = 5;
  localparam logic [PIN_N-1:0] PIN_RST = 6'h30;

  // ----------------------------------------------------------------
  // Modes and data paths
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MD_START = 4'h1,
    MD_DATA = 4'h2,
    MD_LOOP1 = 4'h4,
    MD_LOOP2 = 4'h8
  } dls_mode_t;

  localparam logic [1:0] PATH_NORMAL = 2'h0;
  localparam logic [1:0] PATH_LOOP_CTL = 2'h1;
  localparam logic [1:0] PATH_LOOP_BOTH = 2'h2;
  localparam logic [1:0] PATH_REMOTE = 2'h3;

  typedef struct packed {
    dls_mode_t mode;
    logic [MSW-1:0] unf_ms;
    logic [MSW-1:0] brk_ms;
    logic [MSW-1:0] pat_ms;
    logic [MSW-1:0] flash_ms;
    logic [MSW-1:0] pulse_ms;
    logic [MSW-1:0] blink_ms;
    logic blink_ph;
    logic pat_on;
    logic pat_to;
    logic loop_prev;
    logic pat_prev;
    logic frame_prev;
    logic rate_bad;
    logic rate_done;
  } dls_state_t;

  typedef struct packed {
    logic link;
    logic td_green;
    logic rd_green;
    logic ns;
    logic er;
    logic tm;
    logic cts;
    logic cd;
    logic restart;
    logic pat_en;
    logic [1:0] path;
  } dls_led_t;

  localparam dls_state_t ST_RST = '{mode: MD_START, default: '0};
  localparam dls_led_t LED_RST = '{ns: 1'b1, td_green: 1'b0, rd_green: 1'b0, default: '0};

endpackage

// ### design/dls_top.sv
// Purpose: Link test supervisor: indicators, restart timing, loops, pattern timeout
// Assumes: Framer status and error pulses on the system clock; switches are async pins
// Notes: Registers over AXI4-Lite; all timeouts run off one millisecond tick
//
// Behaviour
// - Link indicator lit while framer link is up, off when down.
// - TD/RD indicators yellow for binary one, green for binary zero.
// - No-signal indicator lit whenever local unit is not linked to remote.
// - After a break, no-signal stays off until ten seconds elapse.
// - Error indicator blinks continuously after a pattern test times out.
// - Error pulse per CRC error in data mode, per bit error during pattern tests.
// - Unsupported DTE rate at power-up blinks error indicator every 200 ms.
// - Test-mode indicator lit in any test mode, local or remote request.
// - Valid management packet flashes test-mode indicator for 400 ms.
// - CTS and CD follow arrival of framed packets from the far end.
// - In data mode, four seconds of unframed packets restart the link.
// - Restart timeout 50 s start-up, 60 s pattern or remote-loop end.
// - Pattern generator stops after 45 s and normal path returns.
// - Timeout blinking ends only when pattern switch, DTE pattern pin and pattern register bit are all released.
// - Pattern injected after the framer, sent unframed for a peer detector.
// - Local loop returns toward local DTE; remote loop returns to line and passes on.
// - Local loop enters mode 1 while no-signal is lit, mode 2 otherwise.
// - Mode 1 loops local DTE data; on exit both units go to start-up.
// - Far unit in mode 1 keeps this unit in start-up, CTS/CD off.
// - Mode 2 loops local data in framer and far data in loop controller.
// - Leaving mode 2 returns to data mode with normal paths.
// - Loops and patterns start from panel switches or DTE request pins.
`timescale 1ns/1ps
`default_nettype none

module dls_top
  import dls_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic [AW-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [AW-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [PIN_N-1:0] I_PINS,
  input wire logic I_FRAME_OK,
  input wire logic I_CRC_ERR,
  input wire logic I_BIT_ERR,
  input wire logic I_RATE_BAD,
  input wire logic I_REMOTE_TEST,
  input wire logic I_RDL_REMOTE,
  input wire logic I_MGMT_PKT,
  output logic O_LINK_UP_INDICATOR,
  output logic O_TD_GREEN,
  output logic O_RD_GREEN,
  output logic O_NO_SIGNAL_INDICATOR,
  output logic O_ERROR_INDICATOR,
  output logic O_TEST_MODE_INDICATOR,
  output logic O_CTS,
  output logic O_CD,
  output logic O_RESTART,
  output logic O_PAT_INJECT,
  output logic [1:0] O_PATH_SEL
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [MSW-1:0] count_down(input logic [MSW-1:0] v, input logic tk);
    count_down = (tk && v != MS_ZERO) ? v - MS_ONE : v;
  endfunction

  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
    hit = (a[AW-1:2] == off[AW-1:2]);
  endfunction

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    if (tick_cnt_q == 32'(TICK_LEN - 1)) begin
      tick_cnt_d = 32'h0;
      tick_d = 1'b1;
    end else begin
      tick_cnt_d = tick_cnt_q + 32'h1;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // A pin changes only once the second and third stages agree
  logic [PIN_N-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;

  always_comb begin
    pin_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s1_q <= PIN_RST;
      s2_q <= PIN_RST;
      s3_q <= PIN_RST;
      pin_q <= PIN_RST;
    end else begin
      s1_q <= I_PINS;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [1:0] ctrl_q, ctrl_d;
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [AW-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  dls_state_t st_q, st_d;
  dls_led_t led_q, led_d;

  always_comb begin
    ctrl_d = ctrl_q;
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (I_AWVALID && awrdy_q) begin
      aw_full_d = 1'b1;
      awaddr_d = I_AWADDR;
    end
    if (I_WVALID && wrdy_q) begin
      w_full_d = 1'b1;
      wdata_d = I_WDATA;
      wstrb0_d = I_WSTRB[0];
    end
    if (bvalid_q && I_BREADY) begin
      bvalid_d = 1'b0;
    end
    if (aw_full_q && w_full_q && !bvalid_q) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      if (hit(awaddr_q, CTRL_OFF)) begin
        bresp_d = RESP_OKAY;
        if (wstrb0_q) begin
          ctrl_d = wdata_q[1:0];
        end
      end else if (hit(awaddr_q, STAT_OFF)) begin
        bresp_d = RESP_OKAY;
      end else begin
        bresp_d = RESP_DECERR;
      end
    end
    awrdy_d = !aw_full_d && !bvalid_d;
    wrdy_d = !w_full_d && !bvalid_d;
    if (rvalid_q && I_RREADY) begin
      rvalid_d = 1'b0;
    end
    if (I_ARVALID && arrdy_q) begin
      rvalid_d = 1'b1;
      if (hit(I_ARADDR, CTRL_OFF)) begin
        rresp_d = RESP_OKAY;
        rdata_d = {30'h0, ctrl_q};
      end else if (hit(I_ARADDR, STAT_OFF)) begin
        rresp_d = RESP_OKAY;
        rdata_d = {22'h0, st_q.rate_bad, st_q.pat_to, st_q.pat_on, led_q.ns, led_q.link,
                   led_q.tm, st_q.mode};
      end else begin
        rresp_d = RESP_DECERR;
        rdata_d = 32'h0;
      end
    end
    arrdy_d = !rvalid_d;
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctrl_q <= CTRL_RST;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb0_q <= 1'b0;
      awrdy_q <= 1'b0;
      wrdy_q <= 1'b0;
      arrdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      awrdy_q <= awrdy_d;
      wrdy_q <= wrdy_d;
      arrdy_q <= arrdy_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Supervisor
  // ----------------------------------------------------------------
  logic loop_req, pat_req, loop_rise, pat_rise, link_up, test_on;
  logic [MSW-1:0] limit;

  always_comb begin
    st_d = st_q;
    led_d = led_q;
    loop_req = pin_q[PIN_LOOP_SW] | pin_q[PIN_DTE_LOOP] | ctrl_q[CTRL_LOOP_BIT];
    pat_req = pin_q[PIN_PAT_SW] | pin_q[PIN_DTE_PAT] | ctrl_q[CTRL_PAT_BIT];
    loop_rise = loop_req && !st_q.loop_prev;
    pat_rise = pat_req && !st_q.pat_prev;
    st_d.loop_prev = loop_req;
    st_d.pat_prev = pat_req;
    st_d.frame_prev = I_FRAME_OK;
    st_d.brk_ms = count_down(st_q.brk_ms, tick_q);
    st_d.pat_ms = count_down(st_q.pat_ms, tick_q);
    st_d.flash_ms = count_down(st_q.flash_ms, tick_q);
    st_d.pulse_ms = count_down(st_q.pulse_ms, tick_q);
    st_d.blink_ms = count_down(st_q.blink_ms, tick_q);
    if (tick_q && st_q.blink_ms == MS_ZERO) begin
      st_d.blink_ms = BLINK_HALF - MS_ONE;
      st_d.blink_ph = !st_q.blink_ph;
    end
    // The rate strap is caught once, in the first cycle after reset release
    if (!st_q.rate_done) begin
      st_d.rate_done = 1'b1;
      st_d.rate_bad = I_RATE_BAD;
    end
    // Pattern test overrides, then remote-loop end, then mode
    if (st_q.pat_on) begin
      limit = PAT_RST_TO;
    end else if (I_RDL_REMOTE) begin
      limit = RDL_TO;
    end else if (st_q.mode == MD_START) begin
      limit = START_TO;
    end else begin
      limit = DATA_TO;
    end
    // Mode 1 deliberately ignores the line, so it never restarts on it
    if (I_FRAME_OK || st_q.mode == MD_LOOP1) begin
      st_d.unf_ms = MS_ZERO;
    end else if (tick_q && st_q.unf_ms != limit) begin
      st_d.unf_ms = st_q.unf_ms + MS_ONE;
    end
    led_d.restart = 1'b0;
    case (st_q.mode)
      MD_START: begin
        if (loop_rise) begin
          st_d.mode = led_q.ns ? MD_LOOP1 : MD_LOOP2;
        end else if (I_FRAME_OK) begin
          st_d.mode = MD_DATA;
        end
      end
      MD_DATA: begin
        if (loop_rise) begin
          st_d.mode = led_q.ns ? MD_LOOP1 : MD_LOOP2;
        end
      end
      MD_LOOP1: begin
        if (!loop_req) begin
          st_d.mode = MD_START;
        end
      end
      MD_LOOP2: begin
        if (!loop_req) begin
          st_d.mode = MD_DATA;
        end
      end
      default: begin
        st_d.mode = MD_START;
      end
    endcase
    if (st_q.mode != MD_LOOP1 && st_q.unf_ms >= limit) begin
      st_d.mode = MD_START;
      st_d.unf_ms = MS_ZERO;
      led_d.restart = 1'b1;
    end
    if (st_q.frame_prev && !I_FRAME_OK && st_q.mode != MD_START) begin
      st_d.brk_ms = BRK_NS;
    end
    // Mode 2 leaves the generator without a data path
    if (pat_rise && !st_q.pat_on && !st_q.pat_to && st_q.mode != MD_LOOP2) begin
      st_d.pat_on = 1'b1;
      st_d.pat_ms = PAT_RUN;
    end else if (st_q.pat_on && st_q.pat_ms == MS_ZERO) begin
      st_d.pat_on = 1'b0;
      st_d.pat_to = 1'b1;
    end
    if (!pat_req) begin
      st_d.pat_on = 1'b0;
      st_d.pat_to = 1'b0;
    end
    if (st_q.pat_on ? I_BIT_ERR : (I_CRC_ERR && st_q.mode == MD_DATA)) begin
      st_d.pulse_ms = ER_PULSE;
    end
    if (I_MGMT_PKT) begin
      st_d.flash_ms = FLASH_LEN;
    end
    link_up = I_FRAME_OK && (st_d.mode == MD_DATA || st_d.mode == MD_LOOP2);
    test_on = st_d.mode == MD_LOOP1 || st_d.mode == MD_LOOP2 || st_d.pat_on || st_d.pat_to
              || I_REMOTE_TEST || I_RDL_REMOTE;
    led_d.link = link_up;
    led_d.ns = !link_up && st_d.brk_ms == MS_ZERO;
    led_d.td_green = !pin_q[PIN_TXD];
    led_d.rd_green = !pin_q[PIN_RXD];
    led_d.er = (st_d.pulse_ms != MS_ZERO) || ((st_d.pat_to || st_d.rate_bad) && st_d.blink_ph);
    led_d.tm = (st_d.flash_ms != MS_ZERO) ? st_d.blink_ph : test_on;
    led_d.cts = I_FRAME_OK;
    led_d.cd = I_FRAME_OK;
    led_d.pat_en = st_d.pat_on;
    if (st_d.mode == MD_LOOP1) begin
      led_d.path = PATH_LOOP_CTL;
    end else if (st_d.mode == MD_LOOP2) begin
      led_d.path = PATH_LOOP_BOTH;
    end else if (I_RDL_REMOTE) begin
      led_d.path = PATH_REMOTE;
    end else begin
      led_d.path = PATH_NORMAL;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_q <= ST_RST;
      led_q <= LED_RST;
    end else begin
      st_q <= st_d;
      led_q <= led_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_AWREADY = awrdy_q;
  assign O_WREADY = wrdy_q;
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;
  assign O_ARREADY = arrdy_q;
  assign O_RVALID = rvalid_q;
  assign O_RRESP = rresp_q;
  assign O_RDATA = rdata_q;
  assign O_LINK_UP_INDICATOR = led_q.link;
  assign O_TD_GREEN = led_q.td_green;
  assign O_RD_GREEN = led_q.rd_green;
  assign O_NO_SIGNAL_INDICATOR = led_q.ns;
  assign O_ERROR_INDICATOR = led_q.er;
  assign O_TEST_MODE_INDICATOR = led_q.tm;
  assign O_CTS = led_q.cts;
  assign O_CD = led_q.cd;
  assign O_RESTART = led_q.restart;
  assign O_PAT_INJECT = led_q.pat_en;
  assign O_PATH_SEL = led_q.path;

endmodule

`default_nettype wire

// ### sim/dls_chk.sv
// Purpose: Port-level assertions of the link test supervisor
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to dls_top from the testbench top file
`timescale 1ns/1ps
`default_nettype none

module dls_chk
  import dls_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic [1:0] O_BRESP,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [PIN_N-1:0] I_PINS,
  input wire logic I_FRAME_OK,
  input wire logic O_LINK_UP_INDICATOR,
  input wire logic O_TD_GREEN,
  input wire logic O_RD_GREEN,
  input wire logic O_NO_SIGNAL_INDICATOR,
  input wire logic O_ERROR_INDICATOR,
  input wire logic O_CTS,
  input wire logic O_CD,
  input wire logic O_RESTART,
  input wire logic O_PAT_INJECT,
  input wire logic [1:0] O_PATH_SEL
);
  // ----------------------------------------------------------------
  // Pattern run length, with slack for tick phase and synchroniser
  // ----------------------------------------------------------------
  localparam int RUN_MAX = int'(PAT_RUN) * TICK_LEN + 4 * TICK_LEN + 8;
  int unsigned run_q;
  int unsigned run_d;

  always_comb begin
    run_d = O_PAT_INJECT ? run_q + 1 : 0;
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      run_q <= 0;
    end else begin
      run_q <= run_d;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  a_cts_frame: assert property ($past(I_RSTN) |-> O_CTS == $past(I_FRAME_OK))
    else $error("cts does not follow framing");
  a_cd_cts: assert property (O_CD == O_CTS)
    else $error("cd and cts differ");
  a_link_no_ns: assert property (O_LINK_UP_INDICATOR |-> !O_NO_SIGNAL_INDICATOR)
    else $error("no-signal lit while linked");
  a_td_green: assert property ((!I_PINS[PIN_TXD])[*7] |=> O_TD_GREEN)
    else $error("td not green on zero");
  a_rd_yellow: assert property (I_PINS[PIN_RXD][*7] |=> !O_RD_GREEN)
    else $error("rd not yellow on one");
  a_restart_once: assert property (O_RESTART |=> !O_RESTART)
    else $error("restart longer than one cycle");
  a_restart_cause: assert property (O_RESTART |-> !$past(I_FRAME_OK, 3))
    else $error("restart while framed");
  a_er_pulse_len: assert property ($rose(O_ERROR_INDICATOR) |-> O_ERROR_INDICATOR[*8])
    else $error("error flash too short");
  a_pat_run_max: assert property (run_q <= RUN_MAX)
    else $error("pattern generator ran too long");
  a_bresp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  a_rdata_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");

  c_restart: cover property (O_RESTART);
  c_loop_one: cover property (O_PATH_SEL == PATH_LOOP_CTL);
  c_loop_two: cover property (O_PATH_SEL == PATH_LOOP_BOTH);
  c_pat_end: cover property ($fell(O_PAT_INJECT));
endmodule

`default_nettype wire

// ### sim/dls_remote_unit.sv
// Purpose: Far-end modem unit seen across the line
// Assumes: Framing lock and loss take LOCK_CYC + 1 cycles
// Notes: Error and management events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

module dls_remote_unit #(
  parameter int LOCK_CYC = 3
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_link_en,
  input wire logic i_crc_req,
  input wire logic i_mgmt_req,
  output logic o_frame_ok,
  output logic o_crc_err,
  output logic o_mgmt_pkt
);
  int lock_q;
  logic crc_prev_q;
  logic mgmt_prev_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lock_q <= 0;
      o_frame_ok <= 1'b0;
      crc_prev_q <= 1'b0;
      mgmt_prev_q <= 1'b0;
      o_crc_err <= 1'b0;
      o_mgmt_pkt <= 1'b0;
    end else begin
      // Framed packets arrive only after the far framer locks
      lock_q <= (o_frame_ok != i_link_en) ? lock_q + 1 : 0;
      if (lock_q >= LOCK_CYC) begin
        o_frame_ok <= i_link_en;
      end
      crc_prev_q <= i_crc_req;
      mgmt_prev_q <= i_mgmt_req;
      o_crc_err <= i_crc_req && !crc_prev_q;
      o_mgmt_pkt <= i_mgmt_req && !mgmt_prev_q;
    end
  end
endmodule

`default_nettype wire

// ### sim/test_link_up_indicator_test_supervisor.sv
// Purpose: Self-checking bench of the link test supervisor
// Assumes: One-cycle tick so every second-scale timeout fits the run
// Notes: Registers over AXI4-Lite, line side from the far-end model
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end

module test_link_up_indicator_test_supervisor;
  import dls_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [AW-1:0] awaddr = '0;
  logic [AW-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [PIN_N-1:0] pins = PIN_RST;
  logic link_en = 1'b0, crc_req = 1'b0, mgmt_req = 1'b0, bit_err = 1'b0, rtest = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, frame_ok, crc_err, mgmt_pkt;
  logic [1:0] bresp, rresp, path;
  logic [31:0] rdata;
  logic link, td_g, rd_g, ns, er, tm, cts, cd, restart, inject;
  int errors = 0;
  int tests_run = 0;
  int n;
  int cnt;

  always #2 i_clk = ~i_clk;

  dls_top #(.TICK_LEN(1)) dut_u (.I_CLK(i_clk), .I_RSTN(i_rstn), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_PINS(pins), .I_FRAME_OK(frame_ok), .I_CRC_ERR(crc_err), .I_BIT_ERR(bit_err), .I_RATE_BAD(1'b0),
    .I_REMOTE_TEST(rtest), .I_RDL_REMOTE(1'b0), .I_MGMT_PKT(mgmt_pkt), .O_LINK_UP_INDICATOR(link),
    .O_TD_GREEN(td_g), .O_RD_GREEN(rd_g), .O_NO_SIGNAL_INDICATOR(ns), .O_ERROR_INDICATOR(er),
    .O_TEST_MODE_INDICATOR(tm), .O_CTS(cts), .O_CD(cd), .O_RESTART(restart), .O_PAT_INJECT(inject),
    .O_PATH_SEL(path));

  dls_remote_unit #(.LOCK_CYC(3)) far_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_link_en(link_en),
    .i_crc_req(crc_req), .i_mgmt_req(mgmt_req), .o_frame_ok(frame_ok), .o_crc_err(crc_err),
    .o_mgmt_pkt(mgmt_pkt));

  // ----------------------------------------------------------------
  // Bus and timing helpers
  // ----------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] exp_r);
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, exp_r)
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp_d, input logic [31:0] m,
                    input logic [1:0] exp_r);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    `CHK(rdata & m, exp_d)
    `CHK(rresp, exp_r)
  endtask

  task automatic count_er(input int k);
    cnt = 0;
    repeat (k) begin
      tick(1);
      cnt += int'(er === 1'b1);
    end
  endtask

  task automatic end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Whole run is about 60k cycles; give it a wide margin
  initial begin
    repeat (75000) @(posedge i_clk);
    errors++;
    end_sim;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    tick(3);
    `CHK(ns, 1'b1)
    `CHK(link, 1'b0)
    rd(CTRL_OFF, 32'(CTRL_RST), 32'h3, RESP_OKAY);
    rd(STAT_OFF, 32'h41, 32'h7f, RESP_OKAY);
    rd(8'h08, 32'h0, 32'hffffffff, RESP_DECERR);
    wr(8'h10, 32'h3, RESP_DECERR);
    wr(STAT_OFF, 32'hf, RESP_OKAY);
    @(posedge i_clk) pins <= '0;
    tick(8);
    `CHK(td_g, 1'b1)
    `CHK(rd_g, 1'b1)
    @(posedge i_clk) pins <= PIN_RST;
    tick(8);
    `CHK(td_g, 1'b0)
    @(posedge i_clk) link_en <= 1'b1;
    tick(20);
    `CHK(cts, 1'b1)
    `CHK(link, 1'b1)
    `CHK(ns, 1'b0)
    rd(STAT_OFF, 32'h22, 32'h7f, RESP_OKAY);
    @(posedge i_clk) crc_req <= 1'b1;
    @(posedge i_clk) crc_req <= 1'b0;
    tick(5);
    `CHK(er, 1'b1)
    tick(60);
    `CHK(er, 1'b0)
    @(posedge i_clk) mgmt_req <= 1'b1;
    @(posedge i_clk) mgmt_req <= 1'b0;
    cnt = 0;
    repeat (400) begin
      tick(1);
      cnt += int'(tm === 1'b1);
    end
    `CHK(cnt > 150 && cnt < 250, 1'b1)
    tick(100);
    `CHK(tm, 1'b0)
    @(posedge i_clk) rtest <= 1'b1;
    tick(3);
    `CHK(tm, 1'b1)
    @(posedge i_clk) rtest <= 1'b0;
    wr(CTRL_OFF, 32'h1, RESP_OKAY);
    tick(10);
    `CHK(path, PATH_LOOP_BOTH)
    `CHK(tm, 1'b1)
    rd(STAT_OFF, 32'h8, 32'hf, RESP_OKAY);
    wr(CTRL_OFF, 32'h0, RESP_OKAY);
    tick(10);
    `CHK(path, PATH_NORMAL)
    rd(STAT_OFF, 32'h2, 32'hf, RESP_OKAY);
    // Line break: restart after 4000 ticks, no-signal after 10000
    @(posedge i_clk) link_en <= 1'b0;
    while (frame_ok) tick(1);
    n = 0;
    while (!restart) begin
      tick(1);
      n++;
    end
    `CHK(n >= 3996 && n <= 4004, 1'b1)
    `CHK(ns, 1'b0)
    tick(9990 - n);
    `CHK(ns, 1'b0)
    tick(20);
    `CHK(ns, 1'b1)
    `CHK(cts, 1'b0)
    rd(STAT_OFF, 32'h41, 32'h7f, RESP_OKAY);
    @(posedge i_clk) pins <= PIN_RST | 6'h01;
    tick(10);
    `CHK(path, PATH_LOOP_CTL)
    `CHK(tm, 1'b1)
    rd(STAT_OFF, 32'h4, 32'hf, RESP_OKAY);
    @(posedge i_clk) pins <= PIN_RST;
    tick(10);
    `CHK(path, PATH_NORMAL)
    rd(STAT_OFF, 32'h1, 32'hf, RESP_OKAY);
    // Pattern from the DTE request pin, left on past its run time
    @(posedge i_clk) pins <= PIN_RST | 6'h08;
    tick(10);
    `CHK(inject, 1'b1)
    @(posedge i_clk) bit_err <= 1'b1;
    @(posedge i_clk) bit_err <= 1'b0;
    tick(3);
    `CHK(er, 1'b1)
    tick(44970);
    `CHK(inject, 1'b1)
    tick(40);
    `CHK(inject, 1'b0)
    `CHK(path, PATH_NORMAL)
    rd(STAT_OFF, 32'h100, 32'h180, RESP_OKAY);
    count_er(450);
    `CHK(cnt > 100 && cnt < 350, 1'b1)
    @(posedge i_clk) pins <= PIN_RST;
    tick(110);
    count_er(300);
    `CHK(cnt, 0)
    end_sim;
  end
endmodule

bind dls_top dls_chk #(.TICK_LEN(TICK_LEN)) chk_u (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .O_BRESP(O_BRESP),
  .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
  .I_PINS(I_PINS), .I_FRAME_OK(I_FRAME_OK), .O_LINK_UP_INDICATOR(O_LINK_UP_INDICATOR),
  .O_TD_GREEN(O_TD_GREEN), .O_RD_GREEN(O_RD_GREEN), .O_NO_SIGNAL_INDICATOR(O_NO_SIGNAL_INDICATOR),
  .O_ERROR_INDICATOR(O_ERROR_INDICATOR), .O_CTS(O_CTS), .O_CD(O_CD), .O_RESTART(O_RESTART),
  .O_PAT_INJECT(O_PAT_INJECT), .O_PATH_SEL(O_PATH_SEL));

`default_nettype wire
